// file: asc_pkg.sv
/*
 * Package for the serial host port start-up and clock-edge logic of a
 * 10-bit converter. Assumes a host that drives chip select, frame sync,
 * serial clock and data in, and a converter core outside this block.
 */
// Function
// - Power up drives end-of-conversion high and clears the input data register.
// - Chip select high then low starts a fresh I/O cycle.
// - Pending-sample flag clears on chip select rise ending the cycle.
// - Input data register is clocked by the serial clock, maybe inverted.
// - Inversion input low inverts the clock feeding the input register.
// - Inverted sampling gives input data an extra half period of setup.
// - Inverted sampling changes output on the same edge input is sampled.
// - Frame sync high at chip select fall: output on falling edges.
// - Frame sync low at chip select fall: output on rising edges.
// - Power-down code enters power-down; next chip select fall powers up.
// - Flag tested at chip select fall; set means read-only; start rise sets it.
package asc_pkg;

    localparam int DATA_W = 10;
    localparam int CMD_W = 4;
    localparam logic [CMD_W-1:0] CMD_POWER_DOWN = 4'h8;
    localparam logic [CMD_W-1:0] CMD_RATE_FAST = 4'h9;
    localparam logic [CMD_W-1:0] CMD_RATE_SLOW = 4'hA;
    localparam logic [DATA_W-1:0] SHIFT_RESET = 10'h000;

    // Link side pins, already resolved to levels
    typedef struct packed {
        logic cs_n;
        logic frame_sync;
        logic sclk;
        logic data_in;
    } asc_pins_s;

    // Word handed from link domain at each cycle end
    typedef struct packed {
        logic [DATA_W-1:0] word;
        logic read_only;
    } asc_word_s;

endpackage

// file: asc_serial_port.sv
/*
 * Serial port of the converter: edge selection, input shift register,
 * output shifting, pending-sample flag, power-down and rate state.
 * Assumes sclk_link is the host clock, free to stop between frames, and
 * that the converter core supplies result and conversion-done on ref_clk.
 */
module asc_serial_port
    import asc_pkg::*;
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link clock (host serial clock as a clock)
    input wire logic sclk_link,
    // Host pins
    input wire logic cs_n,
    input wire logic frame_sync,
    input wire logic data_in,
    input wire logic input_edge_invert,
    input wire logic external_sample_start,
    // Outputs to host
    output logic data_out,
    output logic end_of_conversion,
    // Core side
    input wire logic [asc_pkg::DATA_W-1:0] conv_result,
    input wire logic conv_done,
    output logic [asc_pkg::DATA_W-1:0] rx_word,
    output logic rx_valid,
    output logic read_only_cycle,
    output logic microprocessor_interface_mode,
    output logic power_down,
    output logic rate_slow
);
    import asc_pkg::*;

    // ==========================================================
    // Link domain: input sampling on both edges, selected
    // ==========================================================
    // Wide enough to count one past the last output bit
    localparam int CNT_W = $clog2(DATA_W + 1);

    logic [DATA_W-1:0] res_q;
    logic [DATA_W-1:0] sh_rise_q;
    logic [DATA_W-1:0] sh_fall_q;
    logic [CNT_W-1:0] cnt_rise_q;
    logic [CNT_W-1:0] cnt_fall_q;
    logic mode_mp_q;
    logic inv_l_q;
    logic [DATA_W-1:0] result_l_q;
    logic link_dout;

    // Bit of the held result that stands after cnt output edges, zero once sent
    function automatic logic out_bit(input logic [DATA_W-1:0] w,
                                     input logic [CNT_W-1:0] cnt);
        logic b;
        b = 1'b0;
        if (int'(cnt) < DATA_W)
            b = w[DATA_W-1-int'(cnt)];
        return b;
    endfunction

    function automatic logic sample_on_rise(input logic mp, input logic inv);
        // edge table: MP with inv high, DSP with inv low sample on rise
        return mp ~^ inv;
    endfunction

    // shift from serial clock, no internal clock involved
    always_ff @(posedge sclk_link)
    begin
        if (cs_n)
            sh_rise_q <= SHIFT_RESET;
        else
            sh_rise_q <= {sh_rise_q[DATA_W-2:0], data_in};
    end

    // inverted clock path feeds the same register contents on falling edge
    always_ff @(negedge sclk_link)
    begin
        if (cs_n)
            sh_fall_q <= SHIFT_RESET;
        else
            sh_fall_q <= {sh_fall_q[DATA_W-2:0], data_in};
    end

    // Mode, inversion and the result to send are captured at chip select fall.
    // The result only moves on conv_done, and the host reads after it, so the
    // word is steady when this edge takes it across.
    always_ff @(negedge cs_n)
    begin
        mode_mp_q <= frame_sync;
        inv_l_q <= input_edge_invert;
        result_l_q <= res_q;
    end

    // Output bit counters restart while chip select is high, so the link clock
    // may stop between frames without a load edge being lost.
    // DSP mode shifts output on rising edges
    always_ff @(posedge sclk_link or posedge cs_n)
    begin
        if (cs_n)
            cnt_rise_q <= '0;
        else if (int'(cnt_rise_q) < DATA_W)
            cnt_rise_q <= cnt_rise_q + 1'b1;
    end

    // microprocessor mode shifts output on falling edges
    always_ff @(negedge sclk_link or posedge cs_n)
    begin
        if (cs_n)
            cnt_fall_q <= '0;
        else if (int'(cnt_fall_q) < DATA_W)
            cnt_fall_q <= cnt_fall_q + 1'b1;
    end

    // ==========================================================
    // System domain
    // ==========================================================
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] start_sync;
        logic cs_prev;
        logic start_prev;
        logic pending;
        logic ro;
        logic pd;
        logic slow;
        logic eoc;
        logic mp;
        logic dout;
        logic [DATA_W-1:0] word;
        logic rx_v;
        logic [DATA_W-1:0] res;
    } asc_state_s;

    asc_state_s s_q;
    asc_state_s s_d;
    logic [DATA_W-1:0] link_word;

    assign res_q = s_q.res;
    // inverted sampling (MP on falling, DSP on rising edge) gives the extra half period of setup
    assign link_word = sample_on_rise(mode_mp_q, inv_l_q) ? sh_rise_q : sh_fall_q;
    // output edge follows mode only, so inverted sampling shares it
    // MSB stands from chip select fall; each output edge moves to the next bit
    assign link_dout = mode_mp_q ? out_bit(result_l_q, cnt_fall_q)
                                 : out_bit(result_l_q, cnt_rise_q);

    always_comb
    begin
        s_d = s_q;
        s_d.cs_sync = {s_q.cs_sync[0], cs_n};
        s_d.start_sync = {s_q.start_sync[0], external_sample_start};
        s_d.cs_prev = s_q.cs_sync[1];
        s_d.start_prev = s_q.start_sync[1];
        s_d.rx_v = 1'b0;
        s_d.dout = link_dout;
        // chip select fall begins a fresh cycle
        if (s_q.cs_prev && !s_q.cs_sync[1])
        begin
            // flag tested at chip select fall
            s_d.ro = s_q.pending;
            s_d.mp = mode_mp_q;
            // next chip select fall powers up
            s_d.pd = 1'b0;
            if (!s_q.pending)
                s_d.eoc = 1'b0;
        end
        // Conversion done after the fall test, so a finished result is never hidden
        if (conv_done)
        begin
            s_d.res = conv_result;
            s_d.eoc = 1'b1;
        end
        if (!s_q.cs_prev && s_q.cs_sync[1])
        begin
            // Word is stable: link clock is idle while chip select is high
            s_d.word = link_word;
            s_d.rx_v = 1'b1;
            // flag cleared at chip select rise
            s_d.pending = 1'b0;
            if (link_word[DATA_W-1 -: CMD_W] == CMD_POWER_DOWN)
                s_d.pd = 1'b1;
            if (link_word[DATA_W-1 -: CMD_W] == CMD_RATE_FAST)
                s_d.slow = 1'b0;
            if (link_word[DATA_W-1 -: CMD_W] == CMD_RATE_SLOW)
                s_d.slow = 1'b1;
        end
        // start rise sets the flag; set wins over the clear
        if (!s_q.start_prev && s_q.start_sync[1])
            s_d.pending = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // end-of-conversion high and input register zero at power up
            s_q <= '{cs_sync: 2'b11, start_sync: 2'b11, cs_prev: 1'b1,
                     start_prev: 1'b1, pending: 1'b0, ro: 1'b0, pd: 1'b0,
                     slow: 1'b0, eoc: 1'b1, mp: 1'b0, dout: 1'b0,
                     word: SHIFT_RESET, rx_v: 1'b0, res: SHIFT_RESET};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.dout;
    assign end_of_conversion = s_q.eoc;
    assign rx_word = s_q.word;
    assign rx_valid = s_q.rx_v;
    assign read_only_cycle = s_q.ro;
    assign microprocessor_interface_mode = s_q.mp;
    assign power_down = s_q.pd;
    assign rate_slow = s_q.slow;

endmodule

// file: asc_properties.sv
/* Checker for asc_serial_port, bound to its ports.
   Assumes cs_n is held high for at least 4 ref_clk between frames. */
module asc_checker
    import asc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host pins
    input wire logic cs_n,
    input wire logic frame_sync,
    // Observed outputs
    input wire logic rx_valid,
    input wire logic [asc_pkg::DATA_W-1:0] rx_word,
    input wire logic power_down,
    input wire logic rate_slow,
    input wire logic end_of_conversion,
    input wire logic microprocessor_interface_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Cycle framing
    sequence cs_start; $fell(cs_n); endsequence
    sequence cs_end; $rose(cs_n); endsequence
    sequence cmd(logic [CMD_W-1:0] c); rx_valid && rx_word[DATA_W-1 -: CMD_W] == c; endsequence
    a_reset_state: assert property ($past(rst) |-> end_of_conversion && rx_word == SHIFT_RESET)
        else $error("reset state wrong");
    a_word_after_end: assert property (cs_end |-> ##[1:6] rx_valid)
        else $error("no word after chip select rise");
    a_pd_enter: assert property (cmd(CMD_POWER_DOWN) |-> ##[0:1] power_down)
        else $error("power-down not entered");
    a_pd_wake: assert property (power_down ##0 cs_start |-> ##[1:6] !power_down)
        else $error("power-down not left");
    a_rate_fast: assert property (cmd(CMD_RATE_FAST) |-> ##[0:1] !rate_slow)
        else $error("fast rate not taken");
    a_rate_slow: assert property (cmd(CMD_RATE_SLOW) |-> ##[0:1] rate_slow)
        else $error("slow rate not taken");
    a_mode_mp: assert property (cs_start ##0 frame_sync |-> ##[1:6] microprocessor_interface_mode)
        else $error("mp mode not latched");
    a_mode_dsp: assert property (cs_start ##0 !frame_sync |-> ##[1:6] !microprocessor_interface_mode)
        else $error("dsp mode not latched");
endmodule
bind asc_serial_port asc_checker chk (.*);

// file: asc_host.sv
/* Host serial port model: frames with a 32 ns link clock.
   Assumes the bench waits for each word before the next frame. */
module asc_host (
    // Host pins
    output logic cs_n,
    output logic frame_sync,
    output logic sclk_link,
    output logic data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cs_n = 1'b1;
        frame_sync = 1'b1;
        sclk_link = 1'b0;
        data_in = 1'b0;
    end
    // ==========================================
    // Frame: data is valid only around the sampling edge, so a wrong edge reads inverted bits
    task automatic frame(input logic [9:0] w, input logic fs, input logic inv);
        logic rise;
        rise = (fs == inv);
        // chip select high gap before a fresh cycle
        #40;
        // frame sync and chip select fall together
        frame_sync = fs;
        cs_n = 1'b0;
        #40;
        for (int i = 9; i >= 0; i--)
        begin
            #2 data_in = rise ? w[i] : ~w[i];
            #14 sclk_link = 1'b1;
            #2 data_in = ~data_in;
            #14 sclk_link = 1'b0;
        end
        #20 cs_n = 1'b1;
        data_in = ~data_in;
    endtask
endmodule

// file: adc_serial_init_clocking_tb.sv
/* Bench for asc_serial_port with host model and checker.
   Assumes register outputs settle within 6 ref_clk of cs_n rise. */
module adc_serial_init_clocking_tb;
    import asc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic inv = 1'b1;
    logic start = 1'b0;
    logic done = 1'b0;
    logic cs_n, fs, sclk, din, dout, eoc, rxv, ro, mp, pd, rs;
    logic [DATA_W-1:0] rxw;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    asc_host host (.cs_n(cs_n), .frame_sync(fs), .sclk_link(sclk), .data_in(din));
    asc_serial_port uut (.ref_clk(ref_clk), .rst(rst), .sclk_link(sclk), .cs_n(cs_n),
        .frame_sync(fs), .data_in(din), .input_edge_invert(inv),
        .external_sample_start(start), .data_out(dout), .end_of_conversion(eoc),
        .conv_result(10'h2A5), .conv_done(done), .rx_word(rxw), .rx_valid(rxv),
        .read_only_cycle(ro), .microprocessor_interface_mode(mp), .power_down(pd),
        .rate_slow(rs));
    // ==========================================
    // Tasks
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input logic [9:0] w, input logic f);
        host.frame(w, f, inv);
        for (int n = 0; n < 20 && rxv !== 1'b1; n++)
            @(negedge ref_clk);
        check("rx_word", rxw, w);
        @(negedge ref_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard: the whole sequence needs about 800 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end
    // ==========================================
    // Tests
    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("eoc", eoc, 1'b1);
        check("rx_word", rxw, SHIFT_RESET);
        $display("reset test done");
        for (int k = 0; k < 4; k++)
        begin
            inv = k[0];
            xfer(10'h1B4 ^ k, k[1]);
            check("mode", mp, k[1]);
        end
        $display("edge test done");
        xfer({CMD_RATE_SLOW, 6'h00}, 1'b1);
        check("rate", rs, 1'b1);
        xfer({CMD_RATE_FAST, 6'h3F}, 1'b0);
        check("rate", rs, 1'b0);
        xfer({CMD_POWER_DOWN, 6'h00}, 1'b1);
        check("pd", pd, 1'b1);
        start = 1'b1;
        repeat (4) @(negedge ref_clk);
        start = 1'b0;
        xfer(10'h001, 1'b1);
        check("pd", pd, 1'b0);
        check("read_only", ro, 1'b1);
        xfer(10'h3FE, 1'b1);
        check("read_only", ro, 1'b0);
        check("eoc", eoc, 1'b0);
        done = 1'b1;
        @(negedge ref_clk);
        done = 1'b0;
        @(negedge ref_clk);
        check("eoc", eoc, 1'b1);
        $display("command test done");
        end_sim();
    end
endmodule
